// ---- pkg/frt_pkg.sv ----
package frt_pkg;
  // register byte addresses on the apb
  localparam logic [7:0] OFS_CTRL_ONE = 8'h00;
  localparam logic [7:0] OFS_CTRL_TWO = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_CNT_HI = 8'h0c;
  localparam logic [7:0] OFS_CNT_LO = 8'h10;
  localparam logic [7:0] OFS_ALT_HI = 8'h14;
  localparam logic [7:0] OFS_ALT_LO = 8'h18;
  localparam logic [7:0] OFS_CAP1_HI = 8'h1c;
  localparam logic [7:0] OFS_CAP1_LO = 8'h20;
  localparam logic [7:0] OFS_CAP2_HI = 8'h24;
  localparam logic [7:0] OFS_CAP2_LO = 8'h28;
  // control_reg_one fields
  localparam int CTL1_CAP_IE = 7;
  localparam int CTL1_OVF_IE = 5;
  localparam int CTL1_CAP1_EDGE = 1;
  // control_reg_two fields
  localparam int CTL2_PWM = 7;
  localparam int CTL2_OPM = 6;
  localparam int CTL2_CLK_LSB = 2;
  localparam int CTL2_CAP2_EDGE = 1;
  localparam int CTL2_EXT_EDGE = 0;
  // timer_status_reg fields
  localparam int STAT_CAP1 = 7;
  localparam int STAT_CAP2 = 6;
  localparam int STAT_OVF = 5;
  localparam logic [7:0] CTRL_ONE_RESET = 8'h00;
  localparam logic [7:0] CTRL_TWO_RESET = 8'h00;
  localparam logic [15:0] CNT_RESET = 16'hfffc;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  // timer_clock_select codes
  localparam logic [1:0] CLK_SEL_DIV4 = 2'h0;
  localparam logic [1:0] CLK_SEL_DIV2 = 2'h1;
  localparam logic [1:0] CLK_SEL_DIV8 = 2'h2;
  localparam logic [1:0] CLK_SEL_EXT = 2'h3;
  localparam logic [2:0] DIV2_MASK = 3'h1;
  localparam logic [2:0] DIV4_MASK = 3'h3;
  localparam logic [2:0] DIV8_MASK = 3'h7;
endpackage

// ---- pkg/frt_cap_if.sv ----
`timescale 1ns/10ps
interface frt_cap_if;
  logic [15:0] count;
  logic pin;
  logic edge_sel;
  logic allowed;
  logic high_rd;
  logic low_acc;
  logic stat_seen;
  logic [15:0] value;
  logic flag;
  modport chan (
    input count, pin, edge_sel, allowed, high_rd, low_acc, stat_seen,
    output value, flag
  );
  modport ctrl (
    output count, pin, edge_sel, allowed, high_rd, low_acc, stat_seen,
    input value, flag
  );
endinterface

// ---- hw/frt_prescale.sv ----
`timescale 1ns/10ps
module frt_prescale
  import frt_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] clock_select,
  input wire logic ext_edge_sel,
  input wire logic ext_pin,
  output logic tick
);
  logic [2:0] div;
  logic ext_s1, ext_s2, ext_prev, ext_hit;

  function automatic logic [2:0] div_mask(input logic [1:0] sel);
    case (sel)
      CLK_SEL_DIV2: div_mask = DIV2_MASK;
      CLK_SEL_DIV8: div_mask = DIV8_MASK;
      default: div_mask = DIV4_MASK;
    endcase
  endfunction

  always_ff @(negedge clk) begin
    if (!rst_n) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      ext_s1 <= ext_pin;
      ext_s2 <= ext_s1;
      ext_prev <= ext_s2;
    end
  end

  assign ext_hit = ext_edge_sel ? (ext_s2 & ~ext_prev) : (~ext_s2 & ext_prev);

  always_ff @(posedge clk) begin
    if (!rst_n) div <= 3'h0;
    else div <= div + 3'h1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) tick <= 1'b0;
    else if (clock_select == CLK_SEL_EXT) tick <= ext_hit;
    else tick <= (div & div_mask(clock_select)) == div_mask(clock_select);
  end

  int_tick_a: assert property (@(posedge clk) disable iff (!rst_n)
    (tick && clock_select != CLK_SEL_EXT && $past(clock_select) != CLK_SEL_EXT) |=> !tick)
    else $error("internal tick lasted two cycles");
endmodule

// ---- hw/frt_capture.sv ----
`timescale 1ns/10ps
module frt_capture (
  input wire logic clk,
  input wire logic rst_n,
  frt_cap_if.chan ch
);
  logic pin_s1, pin_s2, pin_prev, inhibit, armed, hit, cap_evt;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      pin_prev <= 1'b0;
    end else begin
      pin_s1 <= ch.pin;
      pin_s2 <= pin_s1;
      pin_prev <= pin_s2;
    end
  end

  assign hit = ch.edge_sel ? (pin_s2 & ~pin_prev) : (~pin_s2 & pin_prev);
  assign cap_evt = hit & ch.allowed & ~inhibit;

  always_ff @(posedge clk) begin
    if (!rst_n) inhibit <= 1'b0;
    else if (ch.high_rd) inhibit <= 1'b1;
    else if (ch.low_acc) inhibit <= 1'b0;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) ch.value <= 16'h0000;
    else if (cap_evt) ch.value <= ch.count;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) armed <= 1'b0;
    else if (ch.stat_seen) armed <= 1'b1;
    else if (ch.low_acc) armed <= 1'b0;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) ch.flag <= 1'b0;
    else if (cap_evt) ch.flag <= 1'b1;
    else if (armed && ch.low_acc) ch.flag <= 1'b0;
  end

  cap_take_a: assert property (@(posedge clk) disable iff (!rst_n)
    cap_evt |=> (ch.flag && ch.value == $past(ch.count)))
    else $error("capture did not store count and flag");

  cap_block_a: assert property (@(posedge clk) disable iff (!rst_n)
    (inhibit && !ch.low_acc) |=> $stable(ch.value))
    else $error("capture value changed while blocked");
endmodule

// ---- hw/frt_top.sv ----
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
// How it works
// - sixteen-bit free up-counter read as bytes
// - primary and alternate pairs show same count
// - write either low byte reloads FFFCh
// - reset starts counter at FFFCh
// - internal period 131072, 262144 or 524288 cycles
// - prescaler divides cpu clock by 2/4/8
// - both select bits set picks external clock
// - edge bit picks active external edge
// - external clock sampled on falling edges
// - high read latches low until low read
// - lone low read returns live count
// - rollover FFFFh to 0000h sets overflow flag
// - overflow irq needs enable and mask clear
// - overflow clears after status read, low access
// - alternate low access never clears overflow
// - halt freezes counter, reset restarts it
// - capture edge copies count, sets flag
// - each channel has own edge bit
// - one capture irq enable for both
// - capture flag clears after status, low access
// - capture high read blocks channel captures
// - newest capture overwrites older value
// - one-pulse or pwm leaves only channel two
// - capture pin two always connected to timer
module frt_top
  import frt_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_timer_clock_pin,
  input wire logic capture_pin_one,
  input wire logic capture_pin_two,
  input wire logic irq_global_mask,
  input wire logic halt_mode,
  output logic timer_irq,
  output logic [15:0] count_value
);

  function automatic logic is_reg(input logic [7:0] addr, input logic [7:0] ofs);
    is_reg = (addr == ofs);
  endfunction

  function automatic logic is_mapped(input logic [7:0] addr);
    case (addr)
      OFS_CTRL_ONE, OFS_CTRL_TWO, OFS_STATUS,
      OFS_CNT_HI, OFS_CNT_LO, OFS_ALT_HI, OFS_ALT_LO,
      OFS_CAP1_HI, OFS_CAP1_LO, OFS_CAP2_HI, OFS_CAP2_LO: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction

  logic [7:0] control_reg_one;
  logic [7:0] control_reg_two;
  logic [7:0] lo_latch;
  logic [15:0] snap;
  logic latch_valid;
  logic overflow_flag;
  logic ovf_armed;
  logic tick;
  logic setup;
  logic access;
  logic wr_acc;
  logic rd_acc;
  logic acc_cnt_lo;
  logic acc_alt_lo;
  logic rd_hi;
  logic rd_lo;
  logic stat_rd;
  logic reload;
  logic advance;
  logic ovf_evt;
  logic alt_mode;
  logic [7:0] next_rdata;
  logic [7:0] status_byte;

  frt_cap_if cap_one ();
  frt_cap_if cap_two ();

  // bus phase decode
  assign setup = psel & ~penable;
  assign access = psel & penable & pready;
  assign wr_acc = access & pwrite;
  assign rd_acc = access & ~pwrite;

  assign acc_cnt_lo = access & is_reg(paddr, OFS_CNT_LO);
  assign acc_alt_lo = access & is_reg(paddr, OFS_ALT_LO);
  // both pairs share latch and count
  assign rd_hi = rd_acc & (is_reg(paddr, OFS_CNT_HI) | is_reg(paddr, OFS_ALT_HI));
  assign rd_lo = rd_acc & (is_reg(paddr, OFS_CNT_LO) | is_reg(paddr, OFS_ALT_LO));
  assign stat_rd = rd_acc & is_reg(paddr, OFS_STATUS);

  assign reload = wr_acc & (is_reg(paddr, OFS_CNT_LO) | is_reg(paddr, OFS_ALT_LO));

  assign advance = tick & ~halt_mode & ~reload;

  assign ovf_evt = advance & (count_value == CNT_MAX);

  // capture one off in pulse modes
  assign alt_mode = control_reg_two[CTL2_PWM] | control_reg_two[CTL2_OPM];

  frt_prescale u_prescale (
    .clk(clk),
    .rst_n(rst_n),
    .clock_select(control_reg_two[CTL2_CLK_LSB +: 2]),
    .ext_edge_sel(control_reg_two[CTL2_EXT_EDGE]),
    .ext_pin(ext_timer_clock_pin),
    .tick(tick)
  );

  // control registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      control_reg_one <= CTRL_ONE_RESET;
      control_reg_two <= CTRL_TWO_RESET;
    end else if (wr_acc) begin
      if (is_reg(paddr, OFS_CTRL_ONE)) control_reg_one <= pwdata[7:0];
      if (is_reg(paddr, OFS_CTRL_TWO)) control_reg_two <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) count_value <= CNT_RESET;
    else if (reload) count_value <= CNT_RESET;
    else if (advance) count_value <= count_value + 16'h0001;
  end

  // count seen by the current read, taken at setup
  always_ff @(posedge clk) begin
    if (!rst_n) snap <= CNT_RESET;
    else if (setup) snap <= count_value;
  end

  // low byte held after high read
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      latch_valid <= 1'b0;
      lo_latch <= 8'h00;
    end else if (rd_hi && !latch_valid) begin
      latch_valid <= 1'b1;
      lo_latch <= snap[7:0];
    end else if (rd_lo) begin
      latch_valid <= 1'b0;
    end
  end

  // arm on status read seeing flag
  always_ff @(posedge clk) begin
    if (!rst_n) ovf_armed <= 1'b0;
    else if (stat_rd && prdata[STAT_OVF]) ovf_armed <= 1'b1;
    else if (acc_cnt_lo) ovf_armed <= 1'b0;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) overflow_flag <= 1'b0;
    else if (ovf_evt) overflow_flag <= 1'b1;
    else if (ovf_armed && acc_cnt_lo) overflow_flag <= 1'b0;
  end

  // capture channel hookup
  assign cap_one.count = count_value;
  assign cap_one.pin = capture_pin_one;
  assign cap_one.edge_sel = control_reg_one[CTL1_CAP1_EDGE];
  assign cap_one.allowed = ~alt_mode;
  assign cap_one.high_rd = rd_acc & is_reg(paddr, OFS_CAP1_HI);
  assign cap_one.low_acc = access & is_reg(paddr, OFS_CAP1_LO);
  assign cap_one.stat_seen = stat_rd & prdata[STAT_CAP1];

  assign cap_two.count = count_value;
  assign cap_two.pin = capture_pin_two;
  assign cap_two.edge_sel = control_reg_two[CTL2_CAP2_EDGE];
  assign cap_two.allowed = 1'b1;
  assign cap_two.high_rd = rd_acc & is_reg(paddr, OFS_CAP2_HI);
  assign cap_two.low_acc = access & is_reg(paddr, OFS_CAP2_LO);
  assign cap_two.stat_seen = stat_rd & prdata[STAT_CAP2];

  frt_capture u_cap_one (
    .clk(clk),
    .rst_n(rst_n),
    .ch(cap_one.chan)
  );

  frt_capture u_cap_two (
    .clk(clk),
    .rst_n(rst_n),
    .ch(cap_two.chan)
  );

  always_comb begin
    status_byte = 8'h00;
    status_byte[STAT_CAP1] = cap_one.flag;
    status_byte[STAT_CAP2] = cap_two.flag;
    status_byte[STAT_OVF] = overflow_flag;
  end

  // read data mux, sampled at setup
  always_comb begin
    next_rdata = 8'h00;
    case (paddr)
      OFS_CTRL_ONE: next_rdata = control_reg_one;
      OFS_CTRL_TWO: next_rdata = control_reg_two;
      OFS_STATUS: next_rdata = status_byte;
      OFS_CNT_HI, OFS_ALT_HI: next_rdata = count_value[15:8];
      OFS_CNT_LO, OFS_ALT_LO: next_rdata = latch_valid ? lo_latch : count_value[7:0];
      OFS_CAP1_HI: next_rdata = cap_one.value[15:8];
      OFS_CAP1_LO: next_rdata = cap_one.value[7:0];
      OFS_CAP2_HI: next_rdata = cap_two.value[15:8];
      OFS_CAP2_LO: next_rdata = cap_two.value[7:0];
      default: next_rdata = 8'h00;
    endcase
  end

  // apb answer one cycle after setup
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup & ~is_mapped(paddr);
      if (setup) prdata <= (!pwrite) ? {24'h00_0000, next_rdata} : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) timer_irq <= 1'b0;
    else timer_irq <= ~irq_global_mask &
      ((overflow_flag & control_reg_one[CTL1_OVF_IE]) |
       ((cap_one.flag | cap_two.flag) & control_reg_one[CTL1_CAP_IE]));
  end

  ctr_reload_a: assert property (@(posedge clk) disable iff (!rst_n)
    reload |=> count_value == CNT_RESET)
    else $error("low byte write did not reload counter");

  rst_value_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(rst_n) |-> count_value == CNT_RESET)
    else $error("counter not at reset value after reset");

  ctr_step_a: assert property (@(posedge clk) disable iff (!rst_n)
    advance |=> count_value == $past(count_value) + 16'h0001)
    else $error("counter did not step by one");

  halt_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (halt_mode && !reload) |=> $stable(count_value))
    else $error("counter moved during halt");

  ovf_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    ovf_evt |=> (overflow_flag && count_value == 16'h0000))
    else $error("rollover did not set overflow flag");

  alt_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
    (overflow_flag && acc_alt_lo) |=> overflow_flag)
    else $error("alternate low access cleared overflow");

  ovf_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(overflow_flag) |-> ($past(acc_cnt_lo) && $past(ovf_armed)))
    else $error("overflow flag cleared without two-step sequence");

  irq_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
    irq_global_mask |=> !timer_irq)
    else $error("interrupt raised while globally masked");

  irq_pend_a: assert property (@(posedge clk) disable iff (!rst_n)
    (overflow_flag && control_reg_one[CTL1_OVF_IE] && !irq_global_mask) |=> timer_irq)
    else $error("pending overflow interrupt not raised");

  latch_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (latch_valid && !rd_lo) |=> $stable(lo_latch))
    else $error("latched low byte changed before low read");

  mode_cap_a: assert property (@(posedge clk) disable iff (!rst_n)
    alt_mode |=> $stable(cap_one.value))
    else $error("channel one captured in pulse mode");

  bus_ready_a: assert property (@(posedge clk) disable iff (!rst_n)
    setup |=> pready ##1 !pready)
    else $error("apb answer not one cycle after setup");

  ctr_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!advance && !reload) |=> $stable(count_value))
    else $error("counter moved without a tick");

  latch_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_hi && !latch_valid) |=> latch_valid)
    else $error("high read did not latch low byte");

  latch_free_a: assert property (@(posedge clk) disable iff (!rst_n)
    rd_lo |=> !latch_valid)
    else $error("low read did not free latch");

  live_lo_a: assert property (@(posedge clk) disable iff (!rst_n)
    (setup && !pwrite && !latch_valid && is_reg(paddr, OFS_ALT_LO)) |=>
      prdata == ({16'h0000, $past(count_value)} & 32'h0000_00ff))
    else $error("lone low read not live count");

  hi_byte_a: assert property (@(posedge clk) disable iff (!rst_n)
    (setup && !pwrite && is_reg(paddr, OFS_CNT_HI)) |=>
      prdata == ({16'h0000, $past(count_value)} >> 8))
    else $error("high byte read wrong");

  alt_hi_a: assert property (@(posedge clk) disable iff (!rst_n)
    (setup && !pwrite && is_reg(paddr, OFS_ALT_HI)) |=>
      prdata == ({16'h0000, $past(count_value)} >> 8))
    else $error("alternate high byte read wrong");

  ovf_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (overflow_flag && !acc_cnt_lo) |=> overflow_flag)
    else $error("overflow flag lost without low access");

  ovf_rise_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(overflow_flag) |-> $past(ovf_evt))
    else $error("overflow flag set without rollover");

  irq_cap_a: assert property (@(posedge clk) disable iff (!rst_n)
    ((cap_one.flag || cap_two.flag) && control_reg_one[CTL1_CAP_IE] && !irq_global_mask) |=> timer_irq)
    else $error("pending capture interrupt not raised");

  irq_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    !((overflow_flag && control_reg_one[CTL1_OVF_IE]) ||
      ((cap_one.flag || cap_two.flag) && control_reg_one[CTL1_CAP_IE])) |=> !timer_irq)
    else $error("interrupt raised without enabled cause");

  bus_err_a: assert property (@(posedge clk) disable iff (!rst_n)
    (setup && !is_mapped(paddr)) |=> (pslverr && prdata == 32'h0000_0000))
    else $error("unmapped access not refused");

  bus_ok_a: assert property (@(posedge clk) disable iff (!rst_n)
    (setup && is_mapped(paddr)) |=> !pslverr)
    else $error("mapped access flagged as error");

endmodule

// ---- verification/frt_pins_model.sv ----
`timescale 1ns/10ps
module frt_pins_model (
  input wire logic clk,
  output logic ext_clk,
  output logic cap_one,
  output logic cap_two
);
  initial begin
    ext_clk = 1'b0;
    cap_one = 1'b0;
    cap_two = 1'b0;
  end
  // pins change just after a rising edge
  task automatic set_pin(input int w, input logic v);
    @(posedge clk);
    if (w == 0) begin
      ext_clk <= v;
    end else if (w == 1) begin
      cap_one <= v;
    end else begin
      cap_two <= v;
    end
  endtask
  task automatic ext_pulses(input int n);
    repeat (n) begin
      set_pin(0, 1'b1);
      repeat (4) @(posedge clk);
      set_pin(0, 1'b0);
      repeat (4) @(posedge clk);
    end
  endtask
endmodule

// ---- verification/testbench.sv ----
`timescale 1ns/10ps
module testbench;
  import frt_pkg::*;
  logic clk, rst_n, psel, penable, pwrite, mask, halt, pready, pslverr, irq, e, ext, c1, c2;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] cnt, q, v;
  int failures, check_count, n;
  logic [5:0] rows [3] = '{{CLK_SEL_DIV4, 4'h4}, {CLK_SEL_DIV2, 4'h2}, {CLK_SEL_DIV8, 4'h8}};
  frt_top i_frt_top (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_timer_clock_pin(ext), .capture_pin_one(c1), .capture_pin_two(c2),
    .irq_global_mask(mask), .halt_mode(halt), .timer_irq(irq), .count_value(cnt));
  frt_pins_model i_frt_pins_model (.clk(clk), .ext_clk(ext), .cap_one(c1), .cap_two(c2));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input string s, input logic [15:0] seen, input logic [15:0] x);
    check_count++;
    if (seen !== x) begin
      failures++;
      $display("BAD %s expected %h seen %h", s, x, seen);
    end
  endtask
  task automatic give_verdict;
    if (failures == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  // one apb transfer, held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata[15:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 8'h00);
  endtask
  // count the clocks until the counter next moves
  task automatic wait_step;
    v = cnt;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (cnt === v && n < 40);
  endtask
  task automatic pin(input int w, input logic lv);
    i_frt_pins_model.set_pin(w, lv);
    cyc(6);
  endtask
  initial begin
    cyc(20000);
    failures++;
    give_verdict();
  end
  initial begin
    {rst_n, psel, penable, pwrite, mask, halt} <= 6'h0;
    paddr <= 8'h00;
    pwdata <= 32'h0;
    failures = 0;
    check_count = 0;
    cyc(3);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      wr(OFS_CTRL_TWO, {4'h0, rows[i][5:4], 2'h0});
      // the first two steps may still follow the old divisor phase
      repeat (3) wait_step();
      chk("step gap", 16'(n), {12'h0, rows[i][3:0]});
    end
    wr(OFS_CTRL_TWO, 8'h04);
    wr(OFS_CTRL_ONE, 8'h20);
    mask <= 1'b1;
    wr(OFS_CNT_LO, 8'h00);
    cyc(20);
    chk("irq masked", 16'(irq), 16'h0);
    rd(OFS_CNT_LO);
    rd(OFS_STATUS);
    chk("ovf set", q, 16'h0020);
    rd(OFS_ALT_LO);
    rd(OFS_STATUS);
    chk("ovf alt", q, 16'h0020);
    mask <= 1'b0;
    cyc(3);
    chk("irq open", 16'(irq), 16'h1);
    rd(OFS_CNT_LO);
    rd(OFS_STATUS);
    chk("ovf clr", q, 16'h0000);
    wr(OFS_CTRL_TWO, 8'h0d);
    wr(OFS_CNT_LO, 8'h00);
    rd(OFS_CNT_HI);
    chk("cnt hi", q, 16'h00ff);
    i_frt_pins_model.ext_pulses(2);
    rd(OFS_CNT_HI);
    rd(OFS_CNT_LO);
    chk("latched lo", q, 16'h00fc);
    rd(OFS_ALT_LO);
    chk("live lo", q, 16'h00fe);
    wr(OFS_CTRL_TWO, 8'h0c);
    pin(0, 1'b1);
    chk("no rise", cnt, 16'hfffe);
    pin(0, 1'b0);
    chk("fall step", cnt, 16'hffff);
    wr(OFS_ALT_LO, 8'h00);
    rd(OFS_ALT_HI);
    rd(OFS_ALT_LO);
    chk("alt reload", q, 16'h00fc);
    wr(OFS_CTRL_ONE, 8'h82);
    pin(1, 1'b1);
    rd(OFS_STATUS);
    chk("cap1 flag", q, 16'h0080);
    chk("cap irq", 16'(irq), 16'h1);
    rd(OFS_CAP1_HI);
    rd(OFS_CAP1_LO);
    chk("cap1 val", q, 16'h00fc);
    rd(OFS_STATUS);
    chk("cap1 clr", q, 16'h0000);
    rd(OFS_CAP1_HI);
    i_frt_pins_model.ext_pulses(1);
    pin(1, 1'b0);
    pin(1, 1'b1);
    rd(OFS_STATUS);
    chk("cap blocked", q, 16'h0000);
    rd(OFS_CAP1_LO);
    chk("cap kept", q, 16'h00fc);
    pin(1, 1'b0);
    pin(1, 1'b1);
    rd(OFS_STATUS);
    rd(OFS_CAP1_HI);
    rd(OFS_CAP1_LO);
    chk("cap newest", q, 16'h00fd);
    pin(2, 1'b1);
    rd(OFS_STATUS);
    chk("cap2 rise", q, 16'h0000);
    pin(2, 1'b0);
    rd(OFS_STATUS);
    chk("cap2 fall", q, 16'h0040);
    wr(OFS_CTRL_TWO, 8'h4c);
    pin(1, 1'b0);
    pin(1, 1'b1);
    rd(OFS_STATUS);
    chk("opm cap1", q, 16'h0040);
    wr(OFS_CTRL_TWO, 8'h04);
    halt <= 1'b1;
    cyc(3);
    v = cnt;
    cyc(20);
    chk("halt hold", cnt, v);
    halt <= 1'b0;
    rst_n <= 1'b0;
    cyc(3);
    rst_n <= 1'b1;
    chk("cnt reset", cnt, CNT_RESET);
    rd(OFS_STATUS);
    chk("sr reset", q, 16'h0000);
    rd(8'h2c);
    chk("unmapped", 16'(e), 16'h1);
    give_verdict();
  end
endmodule
